// File: logic/clsb_core.sv
// execution unit: logic ops, rotate, inc/dec skip, compare skip, bit ops
// Notes on behaviour
// - accumulator OR/XOR immediate nibble into accumulator
// - accumulator OR/XOR direct or pointer-addressed nibble
// - 8-bit AND/OR/XOR, wide acc or chosen pair
// - rotate right through carry flag
// - accumulator ones' complement
// - register increment, skip when zero
// - pointer-capable pair increment, skip when zero
// - memory nibble increment, skip when zero
// - register decrement, skip when all ones
// - pair decrement, skip when all ones
// - register/memory equals immediate skips
// - accumulator equals register/memory skips
// - wide acc equals memory nibble pair skips
// - wide acc equals register pair skips
// - carry set, clear, skip-if-one, invert
// - direct memory bit set and clear
// - indirect memory bit set and clear
// - direct bit test, true or false skip
// - indirect bit test, true or false skip
// - test bit, skip and clear if set
// - carry AND/OR memory bit into carry
`timescale 1ns/1ps

module clsb_core
  import clsb_pkg::*;
#(
  parameter int unsigned MEM_DEPTH = MEM_WORDS
)(
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                op_valid,
  input  wire logic [OP_W-1:0]     op_code,
  input  wire logic [3:0]          imm_nibble,
  input  wire logic [2:0]          reg_sel,
  input  wire logic [2:0]          pair_sel,
  input  wire logic [MEM_AW-1:0]   mem_addr,
  input  wire logic                use_pointer,
  input  wire logic [1:0]          bit_sel,
  output logic [3:0]               acc_q,
  output logic [3:0]               acc_hi_q,
  output logic                     carry_flag_q,
  output logic                     skip_pending_q,
  output logic                     op_done_q
);

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  logic rst_s1_q;
  logic rst_s2_q;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  wire logic srst_n = rst_s2_q;

  // ------------------------------------------------------------------
  // storage: eight nibble registers (pairs are reg 2k/2k+1) and memory
  // ------------------------------------------------------------------
  logic [3:0] regs_q [NREG];
  logic [3:0] mem_q  [MEM_DEPTH];

  clsb_op_e   op;
  logic       exec;
  logic [7:0] ptr;
  logic [7:0] ea;
  logic [7:0] ea_pair;
  logic [3:0] mnib;
  logic [3:0] mnib_hi;
  logic [3:0] rnib;
  logic [7:0] wide;
  logic [7:0] pval;
  logic       mbit;

  assign op      = clsb_op_e'(op_code);
  // a pending skip swallows this instruction whatever it is
  assign exec    = op_valid && !skip_pending_q;
  assign ptr     = {regs_q[REG_H], regs_q[REG_L]};
  assign ea      = use_pointer ? ptr : mem_addr;
  assign ea_pair = {ptr[7:1], 1'b0};
  assign mnib    = mem_q[ea];
  assign mnib_hi = mem_q[ea_pair | 8'h01];
  assign rnib    = regs_q[reg_sel];
  assign wide    = {regs_q[REG_X], regs_q[REG_A]};
  assign pval    = {regs_q[{pair_sel[1:0], 1'b0}],
                    regs_q[{pair_sel[1:0], 1'b1}]};
  assign mbit    = mnib[bit_sel];

  // ------------------------------------------------------------------
  // datapath results
  // ------------------------------------------------------------------
  logic [3:0] acc_d;
  logic [3:0] rnib_d;
  logic [7:0] wide_d;
  logic [7:0] pair_d;
  logic [3:0] mem_d;
  logic       wr_acc;
  logic       wr_reg;
  logic       wr_wide;
  logic       wr_pair;
  logic       wr_mem;
  logic       carry_d;
  logic       skip_d;

  always_comb
  begin
    acc_d   = regs_q[REG_A];
    rnib_d  = rnib;
    wide_d  = wide;
    pair_d  = pval;
    mem_d   = mnib;
    wr_acc  = 1'b0;
    wr_reg  = 1'b0;
    wr_wide = 1'b0;
    wr_pair = 1'b0;
    wr_mem  = 1'b0;
    carry_d = carry_flag_q;
    skip_d  = 1'b0;
    case (op)
      OP_OR_IMM:   begin acc_d = acc_d | imm_nibble; wr_acc = 1'b1; end
      OP_XOR_IMM:  begin acc_d = acc_d ^ imm_nibble; wr_acc = 1'b1; end
      OP_OR_MEM:   begin acc_d = acc_d | mnib; wr_acc = 1'b1; end
      OP_XOR_MEM:  begin acc_d = acc_d ^ mnib; wr_acc = 1'b1; end
      OP_AND_W:    begin wide_d = wide & pval; wr_wide = 1'b1; end
      OP_OR_W:     begin wide_d = wide | pval; wr_wide = 1'b1; end
      OP_XOR_W:    begin wide_d = wide ^ pval; wr_wide = 1'b1; end
      // the wide pair itself is not a legal target here
      OP_AND_P:    begin pair_d = pval & wide; wr_pair = 1'b1; end
      OP_OR_P:     begin pair_d = pval | wide; wr_pair = 1'b1; end
      OP_XOR_P:    begin pair_d = pval ^ wide; wr_pair = 1'b1; end
      OP_ROTC:
      begin
        acc_d   = {carry_flag_q, regs_q[REG_A][3:1]};
        carry_d = regs_q[REG_A][0];
        wr_acc  = 1'b1;
      end
      OP_NOT_A:    begin acc_d = ~acc_d; wr_acc = 1'b1; end
      OP_INC_REG:
      begin
        rnib_d = rnib + 4'h1;
        wr_reg = 1'b1;
        skip_d = (rnib_d == NIB_RST);
      end
      OP_INC_PAIR:
      begin
        pair_d  = pval + 8'h01;
        wr_pair = 1'b1;
        skip_d  = (pair_d == 8'h00);
      end
      OP_INC_MEM:
      begin
        mem_d  = mnib + 4'h1;
        wr_mem = 1'b1;
        skip_d = (mem_d == NIB_RST);
      end
      OP_DEC_REG:
      begin
        rnib_d = rnib - 4'h1;
        wr_reg = 1'b1;
        skip_d = (rnib_d == NIB_ONES);
      end
      OP_DEC_PAIR:
      begin
        pair_d  = pval - 8'h01;
        wr_pair = 1'b1;
        skip_d  = (pair_d == BYTE_ONES);
      end
      OP_CMP_RI:   skip_d = (rnib == imm_nibble);
      OP_CMP_MI:   skip_d = (mnib == imm_nibble);
      OP_CMP_AR:   skip_d = (regs_q[REG_A] == rnib);
      OP_CMP_AM:   skip_d = (regs_q[REG_A] == mnib);
      OP_CMP_WM:   skip_d = (regs_q[REG_A] == mem_q[ea_pair]) &&
                            (regs_q[REG_X] == mnib_hi);
      OP_CMP_WP:   skip_d = (wide == pval);
      OP_CY_SET:   carry_d = 1'b1;
      OP_CY_CLR:   carry_d = 1'b0;
      OP_CY_SKIP:  skip_d = carry_flag_q;
      OP_CY_INV:   carry_d = ~carry_flag_q;
      OP_BIT_SET:
      begin
        mem_d[bit_sel] = 1'b1;
        wr_mem = 1'b1;
      end
      OP_BIT_CLR:
      begin
        mem_d[bit_sel] = 1'b0;
        wr_mem = 1'b1;
      end
      OP_BIT_SKT:  skip_d = mbit;
      OP_BIT_SKF:  skip_d = !mbit;
      OP_BIT_TCLR:
      begin
        skip_d = mbit;
        mem_d[bit_sel] = 1'b0;
        wr_mem = 1'b1;
      end
      OP_CY_ANDB:  carry_d = carry_flag_q & mbit;
      OP_CY_ORB:   carry_d = carry_flag_q | mbit;
      default:     skip_d = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // register file
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NREG; i++)
        regs_q[i] <= NIB_RST;
    end
    else if (!srst_n)
    begin
      for (int i = 0; i < NREG; i++)
        regs_q[i] <= NIB_RST;
    end
    else if (exec)
    begin
      if (wr_acc)
        regs_q[REG_A] <= acc_d;
      if (wr_reg)
        regs_q[reg_sel] <= rnib_d;
      if (wr_wide)
      begin
        regs_q[REG_X] <= wide_d[7:4];
        regs_q[REG_A] <= wide_d[3:0];
      end
      if (wr_pair)
      begin
        regs_q[{pair_sel[1:0], 1'b0}] <= pair_d[7:4];
        regs_q[{pair_sel[1:0], 1'b1}] <= pair_d[3:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // data memory; no reset so it maps onto a plain array
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst_n && exec && wr_mem)
      mem_q[ea] <= mem_d;
  end

  // ------------------------------------------------------------------
  // carry, skip and completion
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      carry_flag_q <= CARRY_RST;
    else if (!srst_n)
      carry_flag_q <= CARRY_RST;
    else if (exec)
      carry_flag_q <= carry_d;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      skip_pending_q <= 1'b0;
    else if (!srst_n)
      skip_pending_q <= 1'b0;
    else if (op_valid)
      skip_pending_q <= exec && skip_d;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      op_done_q <= 1'b0;
    else
      op_done_q <= srst_n && exec;
  end

  assign acc_q    = regs_q[REG_A];
  assign acc_hi_q = regs_q[REG_X];

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!srst_n);

  AST_OR_IMM: assert property (
    exec && op == OP_OR_IMM |=> acc_q == ($past(acc_q) | $past(imm_nibble)))
    else $error("or immediate result wrong");
  AST_XOR_MEM: assert property (
    exec && op == OP_XOR_MEM |=> acc_q == ($past(acc_q) ^ $past(mnib)))
    else $error("xor memory result wrong");
  AST_AND_W: assert property (
    exec && op == OP_AND_W |=> {acc_hi_q, acc_q} == $past(wide & pval))
    else $error("wide and result wrong");
  AST_ROTC: assert property (
    exec && op == OP_ROTC |=> carry_flag_q == $past(acc_q[0]) &&
      acc_q == {$past(carry_flag_q), $past(acc_q[3:1])})
    else $error("rotate through carry wrong");
  AST_NOT: assert property (
    exec && op == OP_NOT_A |=> acc_q == ~$past(acc_q))
    else $error("complement wrong");
  AST_INC_SKIP: assert property (
    exec && op == OP_INC_REG && rnib == NIB_ONES |=> skip_pending_q)
    else $error("increment wrap did not skip");
  AST_DEC_SKIP: assert property (
    exec && op == OP_DEC_REG && rnib == NIB_RST |=> skip_pending_q)
    else $error("decrement wrap did not skip");
  AST_CMP: assert property (
    exec && op == OP_CMP_RI |=> skip_pending_q == $past(rnib == imm_nibble))
    else $error("compare skip wrong");
  AST_CY_INV: assert property (
    exec && op == OP_CY_INV |=> carry_flag_q != $past(carry_flag_q))
    else $error("carry invert wrong");
  AST_SKIP_ONE: assert property (
    skip_pending_q && op_valid |=> !skip_pending_q && !op_done_q)
    else $error("skip did not swallow exactly one op");
  AST_TCLR: assert property (
    exec && op == OP_BIT_TCLR |=> skip_pending_q == $past(mbit))
    else $error("test and clear skip wrong");
  // pair base taken straight from the pointer, low bit forced
  AST_CMP_WM: assert property (
    exec && op == OP_CMP_WM |=> skip_pending_q ==
      $past(acc_q == mem_q[{ptr[7:1], 1'b0}] &&
            acc_hi_q == mem_q[{ptr[7:1], 1'b1}]))
    else $error("wide memory compare skip wrong");
  AST_PAIR_WRAP: assert property (
    exec && op == OP_INC_PAIR && pval == BYTE_ONES |=> skip_pending_q)
    else $error("pair increment wrap did not skip");

  COV_SKIP: cover property (exec && skip_d ##1 op_valid);
  COV_ROT:  cover property (exec && op == OP_ROTC);
  COV_BIT:  cover property (exec && op == OP_BIT_TCLR && mbit);
  COV_WCMP: cover property (exec && op == OP_CMP_WM && skip_d);

endmodule : clsb_core

// File: logic/clsb_pkg.sv
// shared constants and op encodings for the logic/skip/bit execution unit
package clsb_pkg;

  localparam int unsigned NIB_W        = 4;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned MEM_AW       = 8;
  localparam int unsigned MEM_WORDS    = 256;
  localparam int unsigned NREG         = 8;
  localparam int unsigned NPAIR        = 8;
  localparam int unsigned OP_W         = 6;

  // register index: X A H L D E B C
  localparam logic [2:0] REG_X         = 3'h0;
  localparam logic [2:0] REG_A         = 3'h1;
  localparam logic [2:0] REG_H         = 3'h2;
  localparam logic [2:0] REG_L         = 3'h3;

  // pair index 0 is the wide accumulator pair, 1 the pointer pair
  localparam logic [2:0] PAIR_ACC      = 3'h0;

  localparam logic [3:0] NIB_RST       = 4'h0;
  localparam logic       CARRY_RST     = 1'b0;
  localparam logic [3:0] NIB_ONES      = 4'hF;
  localparam logic [7:0] BYTE_ONES     = 8'hFF;

  typedef enum logic [5:0] {
    OP_NOP      = 6'h00,
    OP_OR_IMM   = 6'h01,
    OP_XOR_IMM  = 6'h02,
    OP_OR_MEM   = 6'h03,
    OP_XOR_MEM  = 6'h04,
    OP_AND_W    = 6'h05,
    OP_OR_W     = 6'h06,
    OP_XOR_W    = 6'h07,
    OP_AND_P    = 6'h08,
    OP_OR_P     = 6'h09,
    OP_XOR_P    = 6'h0A,
    OP_ROTC     = 6'h0B,
    OP_NOT_A    = 6'h0C,
    OP_INC_REG  = 6'h0D,
    OP_INC_PAIR = 6'h0E,
    OP_INC_MEM  = 6'h0F,
    OP_DEC_REG  = 6'h10,
    OP_DEC_PAIR = 6'h11,
    OP_CMP_RI   = 6'h12,
    OP_CMP_MI   = 6'h13,
    OP_CMP_AM   = 6'h14,
    OP_CMP_AR   = 6'h15,
    OP_CMP_WM   = 6'h16,
    OP_CMP_WP   = 6'h17,
    OP_CY_SET   = 6'h18,
    OP_CY_CLR   = 6'h19,
    OP_CY_SKIP  = 6'h1A,
    OP_CY_INV   = 6'h1B,
    OP_BIT_SET  = 6'h1C,
    OP_BIT_CLR  = 6'h1D,
    OP_BIT_SKT  = 6'h1E,
    OP_BIT_SKF  = 6'h1F,
    OP_BIT_TCLR = 6'h20,
    OP_CY_ANDB  = 6'h21,
    OP_CY_ORB   = 6'h22
  } clsb_op_e;

endpackage : clsb_pkg

// File: sim/test_cpu_logic_skip_bit_unit.sv
// self-checking bench for the logic, skip and bit execution unit
`timescale 1ns/1ps

module test_cpu_logic_skip_bit_unit
  import clsb_pkg::*;
;
  typedef struct packed {
    logic [OP_W-1:0] op;
    logic [11:0]     arg;
    logic [15:0]     exp;
  } clsb_row_s;

  logic              core_clk;
  logic              rst_n;
  logic              op_valid;
  logic [OP_W-1:0]   op_code;
  logic [3:0]        imm_nibble;
  logic [2:0]        reg_sel;
  logic [2:0]        pair_sel;
  logic [MEM_AW-1:0] mem_addr;
  logic              use_pointer;
  logic [1:0]        bit_sel;
  logic [3:0]        acc_q;
  logic [3:0]        acc_hi_q;
  logic              carry_flag_q;
  logic              skip_pending_q;
  logic              op_done_q;
  logic [15:0]       seen;
  int                failures;
  int                num_checks;
  clsb_row_s         rows[$];

  // packed view: acc, acc_hi, carry digit, {skip, done} digit
  assign seen = {acc_q, acc_hi_q, 3'h0, carry_flag_q, 2'h0,
                 skip_pending_q, op_done_q};

  clsb_core clsb_core_i (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .op_valid       (op_valid),
    .op_code        (op_code),
    .imm_nibble     (imm_nibble),
    .reg_sel        (reg_sel),
    .pair_sel       (pair_sel),
    .mem_addr       (mem_addr),
    .use_pointer    (use_pointer),
    .bit_sel        (bit_sel),
    .acc_q          (acc_q),
    .acc_hi_q       (acc_hi_q),
    .carry_flag_q   (carry_flag_q),
    .skip_pending_q (skip_pending_q),
    .op_done_q      (op_done_q)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // arg digits: imm, reg/pair select, {direct addr bit 0, pointer, bit}
  task automatic drive(input logic [OP_W-1:0] op, input logic [11:0] arg);
    op_valid    <= 1'b1;
    op_code     <= op;
    imm_nibble  <= arg[11:8];
    reg_sel     <= arg[6:4];
    pair_sel    <= arg[6:4];
    use_pointer <= arg[2];
    mem_addr    <= {7'h00, arg[3]};
    bit_sel     <= arg[1:0];
  endtask : drive

  task automatic run_op(input logic [OP_W-1:0] op, input logic [11:0] arg,
                        input logic [15:0] exp);
    @(posedge core_clk);
    drive(op, arg);
    @(posedge core_clk);
    op_valid <= 1'b0;
    #1;
    check("state after op", exp);
  endtask : run_op

  task automatic row(input logic [OP_W-1:0] op, input logic [11:0] arg,
                     input logic [15:0] exp);
    rows.push_back({op, arg, exp});
  endtask : row

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // table: nibble 0 is the shared target, nibble 1 feeds the wide compare
  // ----------------------------------------------------------------
  task automatic fill_rows;
    row(OP_OR_IMM, 12'h500, 16'h5001);
    row(OP_XOR_IMM, 12'hF00, 16'hA001);
    row(OP_NOT_A, 12'h000, 16'h5001);
    row(OP_CY_SET, 12'h000, 16'h5011);
    row(OP_ROTC, 12'h000, 16'hA011);
    row(OP_ROTC, 12'h000, 16'hD001);
    row(OP_CY_INV, 12'h000, 16'hD011);
    row(OP_CY_CLR, 12'h000, 16'hD001);
    row(OP_CY_SKIP, 12'h000, 16'hD001);
    row(OP_INC_REG, 12'h000, 16'hD101);
    row(OP_BIT_CLR, 12'h000, 16'hD101);
    row(OP_BIT_CLR, 12'h001, 16'hD101);
    row(OP_BIT_CLR, 12'h002, 16'hD101);
    row(OP_BIT_CLR, 12'h003, 16'hD101);
    row(OP_BIT_SET, 12'h001, 16'hD101);
    row(OP_XOR_IMM, 12'hD00, 16'h0101);
    row(OP_OR_MEM, 12'h004, 16'h2101);
    row(OP_XOR_MEM, 12'h004, 16'h0101);
    row(OP_BIT_SKT, 12'h001, 16'h0103);
    row(OP_OR_IMM, 12'hF00, 16'h0100);
    row(OP_BIT_SKF, 12'h004, 16'h0103);
    row(OP_OR_IMM, 12'hF00, 16'h0100);
    row(OP_BIT_SKF, 12'h001, 16'h0101);
    row(OP_CY_SET, 12'h000, 16'h0111);
    row(OP_CY_ANDB, 12'h004, 16'h0101);
    row(OP_CY_ORB, 12'h005, 16'h0111);
    row(OP_CY_SKIP, 12'h000, 16'h0113);
    row(OP_OR_IMM, 12'hF00, 16'h0110);
    row(OP_BIT_TCLR, 12'h005, 16'h0113);
    row(OP_OR_IMM, 12'hF00, 16'h0110);
    row(OP_BIT_TCLR, 12'h005, 16'h0111);
    row(OP_BIT_SET, 12'h004, 16'h0111);
    row(OP_BIT_SET, 12'h005, 16'h0111);
    row(OP_BIT_SET, 12'h006, 16'h0111);
    row(OP_BIT_SET, 12'h007, 16'h0111);
    row(OP_INC_MEM, 12'h000, 16'h0113);
    row(OP_OR_IMM, 12'hF00, 16'h0110);
    row(OP_CMP_MI, 12'h004, 16'h0113);
    row(OP_OR_IMM, 12'hF00, 16'h0110);
    row(OP_CMP_RI, 12'h100, 16'h0113);
    row(OP_OR_IMM, 12'hF00, 16'h0110);
    row(OP_CMP_AR, 12'h000, 16'h0111);
    row(OP_CMP_AR, 12'h020, 16'h0113);
    row(OP_OR_IMM, 12'hF00, 16'h0110);
    row(OP_CMP_AM, 12'h004, 16'h0113);
    row(OP_OR_IMM, 12'hF00, 16'h0110);
    row(OP_DEC_REG, 12'h010, 16'hF113);
    row(OP_OR_IMM, 12'hF00, 16'hF110);
    row(OP_INC_REG, 12'h010, 16'h0113);
    row(OP_OR_IMM, 12'hF00, 16'h0110);
    row(OP_DEC_REG, 12'h000, 16'h0011);
    row(OP_DEC_PAIR, 12'h000, 16'hFF13);
    row(OP_OR_IMM, 12'hF00, 16'hFF10);
    row(OP_DEC_PAIR, 12'h020, 16'hFF13);
    row(OP_OR_IMM, 12'hF00, 16'hFF10);
    row(OP_CMP_WP, 12'h020, 16'hFF13);
    row(OP_OR_IMM, 12'hF00, 16'hFF10);
    row(OP_CMP_WP, 12'h010, 16'hFF11);
    row(OP_XOR_W, 12'h000, 16'h0011);
    row(OP_OR_W, 12'h020, 16'hFF11);
    row(OP_XOR_P, 12'h020, 16'hFF11);
    row(OP_CMP_WP, 12'h020, 16'hFF11);
    row(OP_OR_P, 12'h020, 16'hFF11);
    row(OP_CMP_WP, 12'h020, 16'hFF13);
    row(OP_OR_IMM, 12'hF00, 16'hFF10);
    row(OP_AND_W, 12'h010, 16'h0011);
    row(OP_AND_P, 12'h020, 16'h0011);
    row(OP_CMP_WP, 12'h020, 16'h0013);
    row(OP_OR_IMM, 12'hF00, 16'h0010);
    row(OP_DEC_PAIR, 12'h020, 16'h0013);
    row(OP_OR_IMM, 12'hF00, 16'h0010);
    row(OP_INC_PAIR, 12'h020, 16'h0013);
    row(OP_OR_IMM, 12'hF00, 16'h0010);
    row(OP_CMP_WP, 12'h020, 16'h0013);
    row(OP_OR_IMM, 12'hF00, 16'h0010);
    row(OP_BIT_CLR, 12'h008, 16'h0011);
    row(OP_BIT_CLR, 12'h009, 16'h0011);
    row(OP_BIT_SET, 12'h00A, 16'h0011);
    row(OP_BIT_CLR, 12'h00B, 16'h0011);
    row(OP_BIT_SKT, 12'h00A, 16'h0013);
    row(OP_OR_IMM, 12'hF00, 16'h0010);
    row(OP_BIT_CLR, 12'h00A, 16'h0011);
    row(OP_INC_REG, 12'h030, 16'h0011);
    row(OP_CMP_WM, 12'h000, 16'h0013);
    row(OP_OR_IMM, 12'hF00, 16'h0010);
    row(OP_INC_REG, 12'h000, 16'h0111);
    row(OP_CMP_WM, 12'h000, 16'h0111);
    row(OP_DEC_REG, 12'h000, 16'h0011);
  endtask : fill_rows

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_n       = 1'b0;
    op_valid    = 1'b0;
    op_code     = 6'h00;
    imm_nibble  = 4'h0;
    reg_sel     = 3'h0;
    pair_sel    = 3'h0;
    mem_addr    = 8'h00;
    use_pointer = 1'b0;
    bit_sel     = 2'h0;
    failures    = 0;
    num_checks  = 0;
    fill_rows();
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    check("reset state", 16'h0000);
    foreach (rows[i])
      run_op(rows[i].op, rows[i].arg, rows[i].exp);
    $display("test table done");
    // back to back: second op lands while the skip is pending
    @(posedge core_clk);
    drive(OP_DEC_REG, 12'h010);
    @(posedge core_clk);
    drive(OP_NOT_A, 12'h000);
    #1;
    check("first of pair", 16'hF013);
    @(posedge core_clk);
    op_valid <= 1'b0;
    #1;
    check("swallowed second", 16'hF010);
    $display("test back to back done");
    // skip must survive idle cycles
    run_op(OP_INC_REG, 12'h010, 16'h0013);
    repeat (3) @(posedge core_clk);
    #1;
    check("skip held idle", 16'h0012);
    run_op(OP_NOT_A, 12'h000, 16'h0010);
    $display("test idle skip done");
    // mid-run reset clears registers, carry and skip; data memory is not read back after it
    run_op(OP_NOT_A, 12'h000, 16'hF011);
    @(posedge core_clk);
    rst_n <= 1'b0;
    #1;
    check("in reset", 16'h0000);
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    check("after reset", 16'h0000);
    run_op(OP_CMP_RI, 12'h010, 16'h0003);
    run_op(OP_NOT_A, 12'h000, 16'h0000);
    $display("test mid reset done");
    test_done();
  end

endmodule : test_cpu_logic_skip_bit_unit
